/* File: rtl/mrcc_clkgen.sv */
/*
  Oscillator model, system clock divider and real-time divider chain.
  Produces one-cycle hclk pulses for instruction cycle and final
  real-time tick. Assumes hclk is much faster than the oscillator.
*/
`timescale 1ns/1ps
module mrcc_clkgen
  import mrcc_pkg::*;
#(
  parameter int OSC_HALF   = MRCC_OSC_HALF,
  parameter int RTC_STAGES = MRCC_RTC_STAGES,
  parameter bit TICK_2HZ   = 1'b0
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic div_sel,
  output logic      sys_tick,
  output logic      rtc_tick
);
  typedef struct packed {
    logic [15:0]           pre;
    logic [1:0]            sys;
    logic [RTC_STAGES-1:0] rtc;
    logic                  sys_tick;
    logic                  rtc_tick;
  } mrcc_clk_t;

  mrcc_clk_t c_q;
  mrcc_clk_t c_d;
  logic      osc_edge;
  logic [1:0] sys_top;
  logic [RTC_STAGES-1:0] rtc_top;

  always_comb begin
    c_d = c_q;
    osc_edge = (c_q.pre == 16'(2 * OSC_HALF - 1));
    c_d.pre = osc_edge ? 16'h0000 : c_q.pre + 16'h0001;
    // Divide by 2 or by 4 of the oscillator
    sys_top = div_sel ? MRCC_DIV4 : MRCC_DIV2;
    c_d.sys_tick = 1'b0;
    if (osc_edge) begin
      if (c_q.sys >= sys_top) begin
        c_d.sys = 2'h0;
        c_d.sys_tick = 1'b1;
      end else begin
        c_d.sys = c_q.sys + 2'h1;
      end
    end
    // Final stage at 1 Hz, or one stage earlier at 2 Hz
    rtc_top = TICK_2HZ ? {1'b0, {(RTC_STAGES-1){1'b1}}}
                       : {RTC_STAGES{1'b1}};
    c_d.rtc_tick = 1'b0;
    if (osc_edge) begin
      if (c_q.rtc >= rtc_top) begin
        c_d.rtc = '0;
        c_d.rtc_tick = 1'b1;
      end else begin
        c_d.rtc = c_q.rtc + RTC_STAGES'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign sys_tick = c_q.sys_tick;
  assign rtc_tick = c_q.rtc_tick;
endmodule : mrcc_clkgen

/* File: rtl/mrcc_pkg.sv */
/*
  Package for the mode register and clock control block: register map,
  field positions, reset values, timing constants and bus encodings.
  Assumes a 32-bit AHB-Lite register bus clocked by hclk at 20 MHz.
*/
package mrcc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] MRCC_OFF_MELODY = 8'h00;
  localparam logic [7:0] MRCC_OFF_IMASK  = 8'h04;
  localparam logic [7:0] MRCC_OFF_DISP   = 8'h08;
  localparam logic [7:0] MRCC_OFF_PORT0  = 8'h0c;
  localparam logic [7:0] MRCC_OFF_PORT1  = 8'h10;
  localparam logic [7:0] MRCC_OFF_PORT2  = 8'h14;
  localparam logic [7:0] MRCC_OFF_FLAGS  = 8'h18;
  localparam logic [7:0] MRCC_OFF_CMD    = 8'h1c;
  localparam logic [7:0] MRCC_OFF_PIN    = 8'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MRCC_MEL_RUN    = 0;
  localparam int MRCC_MEL_END    = 1;
  localparam int MRCC_IM_EXT     = 0;
  localparam int MRCC_IM_DIV     = 2;
  localparam int MRCC_DC_DISP    = 0;
  localparam int MRCC_DC_BOOST   = 1;
  localparam int MRCC_DC_DIVSEL  = 2;
  localparam int MRCC_FL_CARRY   = 0;
  localparam int MRCC_FL_EXT     = 1;
  localparam int MRCC_FL_DIV     = 2;
  localparam int MRCC_CMD_ENDTST = 0;
  localparam int MRCC_CMD_CSET   = 1;
  localparam int MRCC_CMD_CCLR   = 2;
  localparam int MRCC_CMD_ECLR   = 3;
  localparam int MRCC_CMD_DCLR   = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] MRCC_RST_MODE = 4'h0;
  localparam logic [3:0] MRCC_RST_PORT = 4'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MRCC_HCLK_HZ    = 20000000;
  localparam int MRCC_OSC_HZ     = 32768;
  // Oscillator half period in hclk cycles, rounded down
  localparam int MRCC_OSC_HALF   = MRCC_HCLK_HZ / (2 * MRCC_OSC_HZ);
  localparam int MRCC_RTC_STAGES = 15;
  localparam logic [1:0] MRCC_DIV2 = 2'h1;
  localparam logic [1:0] MRCC_DIV4 = 2'h3;

  // AHB encodings
  localparam logic [1:0] MRCC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] MRCC_HSIZE_WORD    = 3'h2;

endpackage : mrcc_pkg

/* File: rtl/mrcc_sync.sv */
/*
  Two-flop level synchroniser for pin inputs.
  Assumes the input is asynchronous to hclk.
*/
`timescale 1ns/1ps
module mrcc_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } mrcc_sync_t;

  mrcc_sync_t s_q;
  mrcc_sync_t s_d;

  always_comb begin
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.sync;
endmodule : mrcc_sync

/* File: rtl/mrcc_top.sv */
/*
  Mode registers, port output latches, flags and clock control of a
  small 4-bit controller, reached over AHB-Lite. Assumes a single
  master, single word transfers, and external melody and pin logic.
*/
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - Run bit 0 stops melody, 1 starts from current ROM pointer.
// - End flag set at stop code, cleared only by end test command.
// - External mask 0 blocks external request, 1 accepts it.
// - Divider mask 0 blocks divider request, 1 accepts it.
// - Display bit 0 turns LCD drive off, 1 turns it on.
// - Booster bit 0 stops booster, 1 runs it.
// - Divide select 0 gives oscillator/2, 1 gives oscillator/4.
// - One system clock period equals one instruction cycle.
// - Two-word instructions take two instruction cycles.
// - After reset the system clock runs at divide-by-2.
// - Crystal gives 16.384 or 8.192 kHz; RC gives 20 or 10 kHz.
// - Real-time divider final tick is 1 Hz or 2 Hz by build option.
// - Three port latches drive pins, loaded by output writes.
// - Mode registers are written like the port latches.
// - Input read returns external interrupt pin level in bit 0.
// - Carry, external and divider request flags, settable and testable.
module mrcc_top
  import mrcc_pkg::*;
#(
  parameter int OSC_HALF   = MRCC_OSC_HALF,
  parameter int RTC_STAGES = MRCC_RTC_STAGES,
  parameter bit TICK_2HZ   = 1'b0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_int_pin,
  input  wire logic        melody_stop_code,
  input  wire logic        two_word_instr,
  output logic             melody_run_ff,
  output logic             display_on,
  output logic             booster_on,
  output logic             clock_div_select,
  output logic             ext_int_req,
  output logic             divider_int_req,
  output logic             instr_strobe,
  output logic             divider_final_tick,
  output logic      [3:0]  first_output_latch,
  output logic      [3:0]  second_output_latch,
  output logic      [3:0]  third_output_latch
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    MRCC_IC_FIRST  = 1'b0,
    MRCC_IC_SECOND = 1'b1
  } mrcc_ic_t;

  // State of the block outside the synchronisers and clock generator, registered in one place
  typedef struct packed {
    logic       ph_wr;
    logic       ph_rd;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic       run;
    logic       mel_end;
    logic       mask_ext;
    logic       mask_div;
    logic       disp;
    logic       boost;
    logic       divsel;
    logic [3:0] p0;
    logic [3:0] p1;
    logic [3:0] p2;
    logic       carry;
    logic       ext_pend;
    logic       div_pend;
    logic       pin_prev;
    logic       stop_prev;
    logic       ext_req;
    logic       div_req;
    mrcc_ic_t   ic;
    logic       istrobe;
    logic       rtc_tick;
  } mrcc_top_t;

  mrcc_top_t r_q;
  mrcc_top_t r_d;

  logic pin_s;
  logic stop_s;
  logic sys_tick;
  logic rtc_tick;

  // ---------------------------------------------------------------
  // Decode helper
  // ---------------------------------------------------------------
  // Exact byte match; upper address bits are not decoded
  function automatic logic mrcc_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    mrcc_hit = (a == off);
  endfunction : mrcc_hit

  // ---------------------------------------------------------------
  // Pin synchronisers and clock generation
  // ---------------------------------------------------------------
  mrcc_sync u_sync_pin (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (ext_int_pin),
    .sync_out (pin_s)
  );

  mrcc_sync u_sync_stop (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (melody_stop_code),
    .sync_out (stop_s)
  );

  mrcc_clkgen #(
    .OSC_HALF   (OSC_HALF),
    .RTC_STAGES (RTC_STAGES),
    .TICK_2HZ   (TICK_2HZ)
  ) u_clkgen (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .div_sel  (r_q.divsel),
    .sys_tick (sys_tick),
    .rtc_tick (rtc_tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       take;
    logic [3:0] wd;
    logic       stop_evt;
    logic       ext_evt;
    logic [31:0] rd;
    take = 1'b0;
    wd = 4'h0;
    stop_evt = 1'b0;
    ext_evt = 1'b0;
    rd = 32'h0000_0000;
    r_d = r_q;
    // Size is not decoded: only whole-word transfers are expected
    take = hsel && hready && (htrans == MRCC_HTRANS_NONSEQ);
    r_d.ph_wr = take && hwrite;
    r_d.ph_rd = take && !hwrite;
    r_d.ph_addr = haddr[7:0];
    wd = hwdata[3:0];

    // Data phase write, one cycle after the address phase
    if (r_q.ph_wr) begin
      if (mrcc_hit(r_q.ph_addr, MRCC_OFF_MELODY)) begin
        // Run bit loads; upper bits are write-zero-only and ignored
        r_d.run = wd[MRCC_MEL_RUN];
      end
      if (mrcc_hit(r_q.ph_addr, MRCC_OFF_IMASK)) begin
        r_d.mask_ext = wd[MRCC_IM_EXT];
        r_d.mask_div = wd[MRCC_IM_DIV];
      end
      if (mrcc_hit(r_q.ph_addr, MRCC_OFF_DISP)) begin
        r_d.disp   = wd[MRCC_DC_DISP];
        r_d.boost  = wd[MRCC_DC_BOOST];
        r_d.divsel = wd[MRCC_DC_DIVSEL];
      end
      if (mrcc_hit(r_q.ph_addr, MRCC_OFF_PORT0)) begin
        r_d.p0 = wd;
      end
      if (mrcc_hit(r_q.ph_addr, MRCC_OFF_PORT1)) begin
        r_d.p1 = wd;
      end
      if (mrcc_hit(r_q.ph_addr, MRCC_OFF_PORT2)) begin
        r_d.p2 = wd;
      end
      if (mrcc_hit(r_q.ph_addr, MRCC_OFF_CMD)) begin
        if (hwdata[MRCC_CMD_ENDTST]) begin
          r_d.mel_end = 1'b0;
        end
        if (hwdata[MRCC_CMD_CCLR]) begin
          r_d.carry = 1'b0;
        end
        if (hwdata[MRCC_CMD_CSET]) begin
          r_d.carry = 1'b1;
        end
        if (hwdata[MRCC_CMD_ECLR]) begin
          r_d.ext_pend = 1'b0;
        end
        if (hwdata[MRCC_CMD_DCLR]) begin
          r_d.div_pend = 1'b0;
        end
      end
    end

    // Hardware events win over a clear in the same cycle
    // The stop code is a level; only its rising edge sets the end flag
    stop_evt = stop_s && !r_q.stop_prev;
    r_d.stop_prev = stop_s;
    if (stop_evt) begin
      r_d.mel_end = 1'b1;
    end
    // Pin idles high; a falling edge marks an external request
    ext_evt = r_q.pin_prev && !pin_s;
    r_d.pin_prev = pin_s;
    if (ext_evt) begin
      r_d.ext_pend = 1'b1;
    end
    if (rtc_tick) begin
      r_d.div_pend = 1'b1;
    end
    r_d.rtc_tick = rtc_tick;

    // Requests lag the pending flags and masks by one cycle
    r_d.ext_req = r_q.ext_pend && r_q.mask_ext;
    r_d.div_req = r_q.div_pend && r_q.mask_div;

    // Instruction cycle strobe; a two-word instruction spends two
    r_d.istrobe = 1'b0;
    if (sys_tick) begin
      case (r_q.ic)
        MRCC_IC_FIRST: begin
          // Length is read only when an instruction starts
          if (two_word_instr) begin
            r_d.ic = MRCC_IC_SECOND;
          end else begin
            r_d.istrobe = 1'b1;
          end
        end
        MRCC_IC_SECOND: begin
          r_d.ic = MRCC_IC_FIRST;
          r_d.istrobe = 1'b1;
        end
        default: begin
          r_d.ic = MRCC_IC_FIRST;
        end
      endcase
    end

    // Read data, registered for the data phase
    // Registers are read as they stand in the address phase, so a read
    // right behind a write to the same register returns the old value
    if (take && !hwrite) begin
      case (haddr[7:0])
        MRCC_OFF_MELODY: rd[1:0] = {r_q.mel_end, r_q.run};
        MRCC_OFF_IMASK:  rd[3:0] = {1'b0, r_q.mask_div, 1'b0, r_q.mask_ext};
        MRCC_OFF_DISP:   rd[3:0] = {1'b0, r_q.divsel, r_q.boost, r_q.disp};
        MRCC_OFF_PORT0:  rd[3:0] = r_q.p0;
        MRCC_OFF_PORT1:  rd[3:0] = r_q.p1;
        MRCC_OFF_PORT2:  rd[3:0] = r_q.p2;
        MRCC_OFF_FLAGS:  rd[2:0] = {r_q.div_pend, r_q.ext_pend, r_q.carry};
        MRCC_OFF_PIN:    rd[0]   = pin_s;
        default:         rd      = 32'h0000_0000;
      endcase
    end
    r_d.rdata = rd;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Zero wait states: the slave is always ready and always OKAY
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = r_q.rdata;
  assign melody_run_ff       = r_q.run;
  assign display_on          = r_q.disp;
  assign booster_on          = r_q.boost;
  assign clock_div_select    = r_q.divsel;
  assign ext_int_req         = r_q.ext_req;
  assign divider_int_req     = r_q.div_req;
  assign instr_strobe        = r_q.istrobe;
  assign divider_final_tick  = r_q.rtc_tick;
  assign first_output_latch  = r_q.p0;
  assign second_output_latch = r_q.p1;
  assign third_output_latch  = r_q.p2;

endmodule : mrcc_top

/* File: tb/mrcc_checker.sv */
/*
  Concurrent checks on the ports of mrcc_top, bound after endmodule.
  Assumes one AHB-Lite master and whole-word single transfers.
*/
`timescale 1ns/1ps
module mrcc_checker
  import mrcc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        melody_run_ff,
  input wire logic        display_on,
  input wire logic        booster_on,
  input wire logic        clock_div_select,
  input wire logic        ext_int_req,
  input wire logic        divider_int_req,
  input wire logic        instr_strobe,
  input wire logic [3:0]  first_output_latch
);
  logic       wr_q;
  logic       rd_q;
  logic [7:0] adr_q;
  logic       take;

  // Marks the data phase, so checks line up with hwdata and hrdata
  assign take = hsel && hready && htrans == MRCC_HTRANS_NONSEQ;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wr_q  <= take && hwrite;
      rd_q  <= take && !hwrite;
      adr_q <= haddr[7:0];
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_run_write: assert property (
    wr_q && adr_q == MRCC_OFF_MELODY |=> melody_run_ff == $past(hwdata[0]))
    else $error("melody run output does not follow write");
  a_disp_write: assert property (
    wr_q && adr_q == MRCC_OFF_DISP |=>
      {clock_div_select, booster_on, display_on} == $past(hwdata[2:0]))
    else $error("display clock outputs do not follow write");
  a_ext_masked: assert property (
    wr_q && adr_q == MRCC_OFF_IMASK && !hwdata[0] |-> ##2 !ext_int_req[*3])
    else $error("external request passes a clear mask");
  a_div_masked: assert property (
    wr_q && adr_q == MRCC_OFF_IMASK && !hwdata[2] |-> ##2 !divider_int_req[*3])
    else $error("divider request passes a clear mask");
  a_latch_write: assert property (
    wr_q && adr_q == MRCC_OFF_PORT0 |=> first_output_latch == $past(hwdata[3:0]))
    else $error("first latch does not follow write");
  a_reset_clear: assert property (
    $rose(hresetn) |-> !melody_run_ff && !display_on && !booster_on &&
      !clock_div_select && !ext_int_req && first_output_latch == 4'h0)
    else $error("outputs not clear after reset");
  a_strobe_pulse: assert property (
    instr_strobe |=> !instr_strobe[*3])
    else $error("instruction strobe too close");
  a_unmapped_zero: assert property (
    rd_q && adr_q > MRCC_OFF_PIN |-> hrdata == 32'h0)
    else $error("unmapped read not zero");

  c_run_write: cover property (wr_q && adr_q == MRCC_OFF_MELODY);
  c_ext_req: cover property (ext_int_req);
  c_div_req: cover property (divider_int_req);
endmodule : mrcc_checker

bind mrcc_top mrcc_checker mrcc_checker_inst (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .melody_run_ff, .display_on, .booster_on, .clock_div_select,
  .ext_int_req, .divider_int_req, .instr_strobe, .first_output_latch);

/* File: tb/mrcc_core_model.sv */
/*
  Stand-in for the instruction core: tells the block whether the
  instruction in progress is two words. Assumes the bench picks the next.
*/
`timescale 1ns/1ps
module mrcc_core_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic instr_strobe,
  input  wire logic two_word_next,
  output logic      two_word_instr
);
  // Length changes only between instructions, as a real core would
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      two_word_instr <= 1'b0;
    end else if (instr_strobe) begin
      two_word_instr <= two_word_next;
    end
  end
endmodule : mrcc_core_model

/* File: tb/mrcc_top_bench.sv */
/*
  Self-checking bench for mrcc_top: AHB-Lite master, pin drivers and
  gap timers. Assumes short oscillator and divider parameters.
*/
`timescale 1ns/1ps
module mrcc_top_bench;
  import mrcc_pkg::*;
  localparam int OH = 4;
  localparam int RS = 3;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        rd_ph = 1'b0;
  logic        ext_int_pin = 1'b1;
  logic        melody_stop_code = 1'b0;
  logic        two_word_next = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, two_word_instr, melody_run_ff;
  logic        display_on, booster_on, clock_div_select, ext_int_req;
  logic        divider_int_req, instr_strobe, divider_final_tick;
  logic [3:0]  first_output_latch, second_output_latch;
  logic [3:0]  third_output_latch;
  logic [31:0] exp_q[$];
  logic [31:0] v;
  int          seed = 83580;
  int          error_cnt = 0;
  int          tests_run = 0;
  wire logic [11:0] lat = {third_output_latch, second_output_latch,
                           first_output_latch};

  mrcc_top #(.OSC_HALF(OH), .RTC_STAGES(RS)) mrcc_top_inst (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_int_pin,
    .melody_stop_code, .two_word_instr, .melody_run_ff, .display_on,
    .booster_on, .clock_div_select, .ext_int_req, .divider_int_req,
    .instr_strobe, .divider_final_tick, .first_output_latch,
    .second_output_latch, .third_output_latch);
  mrcc_core_model mrcc_core_model_inst (.hclk, .hresetn, .instr_strobe,
    .two_word_next, .two_word_instr);

  always #25 hclk = ~hclk;

  task automatic complete_run;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // ----------------------------------------------------------------
  // Bus master: waits on hreadyout, assumes no latency
  // ----------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= MRCC_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= MRCC_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_ph) cmp(hrdata, exp_q.pop_front());
  end

  function automatic logic pick(input bit rtc);
    return rtc ? divider_final_tick : instr_strobe;
  endfunction : pick

  // First gap after a change may be partial, so the third pulse counts
  task automatic gap(input bit rtc, input int exp);
    int n;
    n = 0;
    repeat (2) begin
      @(negedge hclk);
      while (pick(rtc) !== 1'b1) @(negedge hclk);
    end
    do begin
      @(negedge hclk);
      n++;
    end while (pick(rtc) !== 1'b1);
    cmp(32'(n), 32'(exp));
  endtask : gap

  task automatic pause(input int n);
    repeat (n) @(posedge hclk);
  endtask : pause

  initial begin
    pause(20000);
    error_cnt++;
    complete_run();
  end

  initial begin
    pause(8);
    hresetn <= 1'b1;
    for (int a = 0; a <= 24; a += 4) rd(8'(a), 32'h0);
    rd(MRCC_OFF_PIN, 32'h1);
    gap(0, 4 * OH);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(MRCC_OFF_DISP, {29'h0, v[2:0]});
      rd(MRCC_OFF_DISP, {29'h0, v[2:0]});
      cmp({clock_div_select, booster_on, display_on}, v[2:0]);
      wr(MRCC_OFF_IMASK, v & 32'h5);
      rd(MRCC_OFF_IMASK, v & 32'h5);
      for (int k = 0; k < 3; k++) begin
        wr(MRCC_OFF_PORT0 + 8'(4 * k), {28'h0, v[4*k+4 +: 4]});
        rd(MRCC_OFF_PORT0 + 8'(4 * k), {28'h0, v[4*k+4 +: 4]});
        cmp(lat[4*k +: 4], v[4*k+4 +: 4]);
      end
    end
    wr(8'h24, 32'hffffffff);
    rd(8'h24, 32'h0);
    $display("test registers done");
    wr(MRCC_OFF_DISP, 32'h4);
    gap(0, 8 * OH);
    wr(MRCC_OFF_DISP, 32'h0);
    two_word_next <= 1'b1;
    gap(0, 8 * OH);
    two_word_next <= 1'b0;
    gap(1, (1 << RS) * 2 * OH);
    $display("test clocks done");
    wr(MRCC_OFF_MELODY, 32'h1);
    rd(MRCC_OFF_MELODY, 32'h1);
    cmp(melody_run_ff, 1'b1);
    melody_stop_code <= 1'b1;
    pause(6);
    melody_stop_code <= 1'b0;
    rd(MRCC_OFF_MELODY, 32'h3);
    wr(MRCC_OFF_MELODY, 32'h0);
    rd(MRCC_OFF_MELODY, 32'h2);
    cmp(melody_run_ff, 1'b0);
    wr(MRCC_OFF_CMD, 32'h1);
    rd(MRCC_OFF_MELODY, 32'h0);
    $display("test melody done");
    wr(MRCC_OFF_IMASK, 32'h1);
    ext_int_pin <= 1'b0;
    pause(6);
    cmp(ext_int_req, 1'b1);
    rd(MRCC_OFF_PIN, 32'h0);
    wr(MRCC_OFF_CMD, 32'h2);
    @(negedge hclk);
    while (divider_final_tick !== 1'b1) @(negedge hclk);
    rd(MRCC_OFF_FLAGS, 32'h7);
    wr(MRCC_OFF_CMD, 32'h1c);
    rd(MRCC_OFF_FLAGS, 32'h0);
    ext_int_pin <= 1'b1;
    pause(6);
    wr(MRCC_OFF_IMASK, 32'h4);
    ext_int_pin <= 1'b0;
    pause(80);
    cmp(ext_int_req, 1'b0);
    cmp(divider_int_req, 1'b1);
    wr(MRCC_OFF_IMASK, 32'h0);
    pause(3);
    cmp(divider_int_req, 1'b0);
    $display("test interrupts done");
    wr(MRCC_OFF_MELODY, 32'h1);
    hresetn <= 1'b0;
    pause(2);
    hresetn <= 1'b1;
    rd(MRCC_OFF_MELODY, 32'h0);
    $display("test second reset done");
    pause(4);
    complete_run();
  end
endmodule : mrcc_top_bench
